// *** core/select_status_cfg.svh ***
// Constants for the selection-sequence status reporter
`ifndef SELECT_STATUS_CFG_SVH
`define SELECT_STATUS_CFG_SVH

// Register byte offsets
`define OFF_CMD 8'h00
`define OFF_CONFIG 8'h04
`define OFF_STATUS 8'h08
`define OFF_CAUSE 8'h0c
`define OFF_STEP 8'h10

// Command codes accepted in the command register
`define CMD_SELECTED_WITH_ATTENTION_CAUSE 8'h42
`define CMD_SEL_ATN3 8'h46
`define CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP 8'h43

// Config field positions and reset value
`define CFG_EXT_BIT 0
`define CFG_RECV_CMD_BIT 1
`define CFG_RESET 8'h02

// Status field positions
`define STAT_BUSY_BIT 0
`define STAT_ATN_BIT 1
`define STAT_IRQ_BIT 7

// Interrupt cause bits
`define CAUSE_DISC 8'h20
`define CAUSE_BS 8'h10
`define CAUSE_FC 8'h08
`define CAUSE_SELATN 8'h02
`define CAUSE_SEL 8'h01
`define CAUSE_RESET 8'h00

// Step counter values and width
`define STEP_W 3
`define STEP_RESET 3'h0

// Bus phase codes
`define PH_MSG_OUT 3'h6
`define PH_CMD 3'h2

`endif

// *** core/select_status_pkg.sv ***
// Types shared by the selection-sequence status reporter
package select_status_pkg;

  // One-hot sequencer states
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ARB = 10'h002,
    S_SEL = 10'h004,
    S_WAIT_MO = 10'h008,
    S_MSGOUT = 10'h010,
    S_WAIT_CMD = 10'h020,
    S_ICMD = 10'h040,
    S_TLOAD = 10'h080,
    S_TMSG = 10'h100,
    S_TCMD = 10'h200
  } seq_state_t;

  // Events from the bus phase logic, same clock
  typedef struct packed {
    logic arb_won;
    logic sel_done;
    logic sel_timeout;
    logic phase_valid;
    logic [2:0] phase;
    logic byte_done;
    logic parity_err;
    logic invalid_id;
    logic cdb_done;
    logic selected;
    logic selected_with_attention_cause;
    logic atn_in;
    logic [2:0] bus_id;
  } bus_ev_t;

  // Byte pushed into the controller FIFO
  typedef struct packed {
    logic push;
    logic [7:0] data;
  } fifo_wr_t;

endpackage : select_status_pkg

// *** core/select_status.sv ***
// Selection-sequence sequencer with step counter, cause register and APB slave
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "select_status_cfg.svh"

module select_status
  import select_status_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus phase events
  input wire bus_ev_t ev,
  // Bus side outputs
  output logic atn_out,
  output fifo_wr_t fifo_wr,
  output logic irq
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------

  // True for every mapped register offset
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFF_CMD) || (a == `OFF_CONFIG) || (a == `OFF_STATUS) ||
              (a == `OFF_CAUSE) || (a == `OFF_STEP);
  endfunction : addr_ok

  seq_state_t state; // Sequencer state
  seq_state_t next_state; // Its next value
  logic [7:0] cmd; // Command being run
  logic [7:0] config_reg; // Software options
  logic [`STEP_W-1:0] step; // Step counter
  logic [`STEP_W-1:0] next_step; // Its next value
  logic [7:0] cause; // Interrupt cause bits
  logic [7:0] set_cause; // Causes raised this cycle
  logic do_stop; // Sequence stops this cycle
  logic next_atn; // Next ATN drive
  logic [1:0] mcnt; // Message bytes handled
  logic [1:0] next_mcnt; // Its next value
  logic atn_seen; // Initiator raised ATN in command phase
  logic ext_run; // Extended option latched for this selection
  logic access; // APB access phase
  logic wr_cmd; // Command register write
  logic rd_clear; // Cause read while interrupt is up
  logic idle_free; // Ready to take a command or selection
  fifo_wr_t next_fifo; // Next FIFO write

  assign access = psel && penable;
  assign wr_cmd = access && pwrite && (paddr == `OFF_CMD);
  assign rd_clear = access && !pwrite && (paddr == `OFF_CAUSE) && irq;
  assign idle_free = (state == S_IDLE) && !irq;

  // Zero-wait slave; read data was captured in the setup cycle
  assign pready = access;
  assign pslverr = access && !addr_ok(paddr);

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------

  // Next-state logic for both the initiator and the target flows
  always_comb begin
    next_state = state;
    next_step = step;
    next_atn = atn_out;
    next_mcnt = mcnt;
    set_cause = 8'h00;
    do_stop = 1'b0;
    next_fifo = '0;
    case (state)
      S_IDLE: begin
        if (wr_cmd && idle_free) begin
          // Step cleared at command start; ATN is asserted from arbitration on
          next_step = `STEP_RESET;
          next_mcnt = 2'd0;
          if ((pwdata[7:0] == `CMD_SELECTED_WITH_ATTENTION_CAUSE) || (pwdata[7:0] == `CMD_SEL_ATN3) ||
              (pwdata[7:0] == `CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP)) begin
            next_state = S_ARB;
            next_atn = 1'b1;
          end
        end else if (ev.selected && idle_free) begin
          // Selected as target: bus ID goes to the FIFO first
          next_step = `STEP_RESET;
          next_mcnt = 2'd0;
          next_fifo.push = 1'b1;
          next_fifo.data = 8'h01 << ev.bus_id;
          set_cause = ev.selected_with_attention_cause ? `CAUSE_SELATN : `CAUSE_SEL;
          next_state = ev.selected_with_attention_cause ? S_TMSG : S_TLOAD;
        end
      end
      S_ARB: begin
        // Arbitration retries without limit
        if (ev.arb_won) begin
          next_state = S_SEL;
        end
      end
      S_SEL: begin
        if (ev.sel_timeout) begin
          // Timed out: disconnect reported alone, bus released
          set_cause = `CAUSE_DISC;
          next_atn = 1'b0;
          do_stop = 1'b1;
        end else if (ev.sel_done) begin
          next_state = S_WAIT_MO;
        end
      end
      S_WAIT_MO: begin
        if (ev.phase_valid) begin
          if (ev.phase == `PH_MSG_OUT) begin
            next_state = S_MSGOUT;
          end else begin
            // Target skipped message out; ATN left asserted
            set_cause = `CAUSE_BS | `CAUSE_FC;
            do_stop = 1'b1;
          end
        end
      end
      S_MSGOUT: begin
        if (ev.byte_done) begin
          next_mcnt = mcnt + 2'd1;
          if (cmd == `CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP) begin
            // Halt after one byte with ATN still on
            next_step = 3'd1;
            set_cause = `CAUSE_BS | `CAUSE_FC;
            do_stop = 1'b1;
          end else if ((cmd == `CMD_SELECTED_WITH_ATTENTION_CAUSE) || (mcnt == 2'd2)) begin
            // Last message byte sent: release ATN before command phase
            next_atn = 1'b0;
            next_step = 3'd2;
            next_state = S_WAIT_CMD;
          end
        end else if (ev.phase_valid && (ev.phase != `PH_MSG_OUT)) begin
          // Target left message out early; ATN stays on since byte three was not sent
          next_step = 3'd2;
          set_cause = `CAUSE_BS | `CAUSE_FC;
          do_stop = 1'b1;
        end
      end
      S_WAIT_CMD: begin
        if (ev.phase_valid) begin
          if (ev.phase == `PH_CMD) begin
            next_step = 3'd3;
            next_state = S_ICMD;
          end else begin
            set_cause = `CAUSE_BS | `CAUSE_FC;
            do_stop = 1'b1;
          end
        end
      end
      S_ICMD: begin
        if (ev.cdb_done) begin
          // Whole block sent
          next_step = 3'd4;
          set_cause = `CAUSE_BS | `CAUSE_FC;
          do_stop = 1'b1;
        end else if (ev.phase_valid && (ev.phase != `PH_CMD)) begin
          // Unsent bytes remain in the FIFO for software to count
          set_cause = `CAUSE_BS | `CAUSE_FC;
          do_stop = 1'b1;
        end
      end
      S_TLOAD: begin
        // Null message byte follows the bus ID
        next_fifo.push = 1'b1;
        next_fifo.data = 8'h00;
        if (config_reg[`CFG_RECV_CMD_BIT]) begin
          next_step = 3'd1;
          next_state = S_TCMD;
        end else begin
          do_stop = 1'b1;
        end
      end
      S_TMSG: begin
        if (ev.byte_done) begin
          next_mcnt = mcnt + 2'd1;
          if (ev.parity_err || ((mcnt == 2'd0) && ev.invalid_id)) begin
            // Step stays 0 on byte one, 4 on bytes two and three
            do_stop = 1'b1;
          end else if ((mcnt == 2'd2) || ((mcnt == 2'd0) && !ext_run)) begin
            if (ev.atn_in) begin
              set_cause = `CAUSE_BS;
              do_stop = 1'b1;
            end else begin
              next_step = ext_run ? 3'd5 : 3'd1;
              next_state = S_TCMD;
            end
          end else begin
            next_step = 3'd4;
          end
        end
      end
      S_TCMD: begin
        if (ev.byte_done && ev.parity_err) begin
          // Step held at 1 or 5; BS if the initiator wants attention
          set_cause = (atn_seen || ev.atn_in) ? `CAUSE_BS : 8'h00;
          do_stop = 1'b1;
        end else if (ev.cdb_done) begin
          next_step = step + 3'd1;
          set_cause = (atn_seen || ev.atn_in) ? `CAUSE_BS : 8'h00;
          do_stop = 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (do_stop) begin
      next_state = S_IDLE;
    end
  end

  // State, counters and ATN drive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= S_IDLE;
      mcnt <= 2'd0;
      atn_out <= 1'b0;
      fifo_wr <= '0;
    end else begin
      state <= next_state;
      mcnt <= next_mcnt;
      atn_out <= next_atn;
      fifo_wr <= next_fifo;
    end
  end

  // Command and extended option latched at start so a mid-run write cannot change the flow
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd <= 8'h00;
      ext_run <= 1'b0;
    end else if (state == S_IDLE) begin
      if (wr_cmd && idle_free) begin
        cmd <= pwdata[7:0];
      end
      ext_run <= config_reg[`CFG_EXT_BIT];
    end
  end

  // ATN seen from the initiator during target command phase
  always_ff @(posedge ref_clk) begin
    if (reset || (state == S_IDLE)) begin
      atn_seen <= 1'b0;
    end else if ((state == S_TCMD) && ev.atn_in) begin
      atn_seen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------------

  // Step, causes and interrupt; a stop in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step <= `STEP_RESET;
      cause <= `CAUSE_RESET;
      irq <= 1'b0;
    end else if (do_stop || set_cause != 8'h00 || next_step != step) begin
      step <= next_step;
      cause <= (rd_clear ? 8'h00 : cause) | set_cause;
      irq <= irq | do_stop;
    end else if (rd_clear) begin
      step <= `STEP_RESET;
      cause <= `CAUSE_RESET;
      irq <= 1'b0;
    end
  end

  // Software options
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_reg <= `CFG_RESET;
    end else if (access && pwrite && (paddr == `OFF_CONFIG)) begin
      config_reg <= pwdata[7:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_CONFIG: prdata <= {24'h00_0000, config_reg};
        `OFF_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[`STAT_BUSY_BIT] <= (state != S_IDLE);
          prdata[`STAT_ATN_BIT] <= atn_out;
          prdata[`STAT_IRQ_BIT] <= irq;
        end
        `OFF_CAUSE: prdata <= {24'h00_0000, cause};
        `OFF_STEP: prdata <= {29'h0000_0000, step};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  timeout_report_a: assert property ((state == S_SEL) && ev.sel_timeout |=>
    irq && (step == 3'd0) && (cause == `CAUSE_DISC) && !atn_out)
    else $error("selection timeout report wrong");
  no_msgout_a: assert property ((state == S_WAIT_MO) && ev.phase_valid && (ev.phase != `PH_MSG_OUT) |=>
    irq && (step == 3'd0) && (cause == (`CAUSE_BS | `CAUSE_FC)) && atn_out)
    else $error("missing message out report wrong");
  atn_release_a: assert property ((state == S_MSGOUT) && (cmd == `CMD_SELECTED_WITH_ATTENTION_CAUSE) && ev.byte_done |=>
    !atn_out && (step == 3'd2) && (state == S_WAIT_CMD))
    else $error("ATN not released after one byte");
  early_phase_a: assert property ((state == S_ICMD) && ev.phase_valid && (ev.phase != `PH_CMD) && !ev.cdb_done |=>
    irq && (step == 3'd3) && (state == S_IDLE))
    else $error("early phase change report wrong");
  select_done_a: assert property ((state == S_ICMD) && ev.cdb_done |=>
    (step == 3'd4) && (cause == (`CAUSE_BS | `CAUSE_FC)) && irq)
    else $error("select complete report wrong");
  atn3_bytes_a: assert property ((state == S_MSGOUT) && (cmd == `CMD_SEL_ATN3) && ev.byte_done && (mcnt != 2'd2) |=>
    atn_out && (state == S_MSGOUT))
    else $error("ATN dropped before third byte");
  atn_stop_a: assert property ((state == S_MSGOUT) && (cmd == `CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP) && ev.byte_done |=>
    atn_out && (step == 3'd1) && irq && (cause == (`CAUSE_BS | `CAUSE_FC)))
    else $error("select with stop report wrong");
  null_byte_a: assert property (idle_free && !wr_cmd && ev.selected && !ev.selected_with_attention_cause |=>
    (state == S_TLOAD) && (step == 3'd0) ##1 fifo_wr.push && (fifo_wr.data == 8'h00) && (cause == `CAUSE_SEL))
    else $error("target load of null byte wrong");
  ext_done_a: assert property ((state == S_TCMD) && ext_run && ev.cdb_done && !ev.parity_err |=>
    (step == 3'd6) && irq && cause[1])
    else $error("extended selection step wrong");
  read_clear_a: assert property (rd_clear && !do_stop |=>
    !irq && (step == 3'd0) && (cause == 8'h00))
    else $error("cause read did not clear");
  stop_hold_a: assert property (irq && !rd_clear |=> irq && $stable(step) && $stable(cause))
    else $error("status changed before read");

  timeout_seen_c: cover property ((state == S_SEL) && ev.sel_timeout);
  atn3_done_c: cover property ((state == S_ICMD) && (cmd == `CMD_SEL_ATN3) && ev.cdb_done);
  ext_target_c: cover property ((state == S_TCMD) && ext_run ##[1:64] irq);
  clear_c: cover property (rd_clear);

endmodule : select_status

// *** dv/far_scsi_device.sv ***
// Behavioural model of the SCSI device across the bus, seen as phase events
`timescale 1ns/1ps

module far_scsi_device
  import select_status_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Events toward the sequencer
  output bus_ev_t ev
);
  // Initiator ATN level, held between events
  logic atn_level;
  // Idle cycles before each event; raise it to act as a slow device
  int slow;

  initial begin
    atn_level = 1'b0;
    slow = 0;
    ev = '0;
  end

  // ATN gets its own edge so it never lands in the same step as a pulse
  task automatic set_atn(input logic v);
    atn_level = v;
    ev.atn_in <= v;
    @(posedge ref_clk);
  endtask : set_atn

  // Event codes: 0 arb won, 1 select done, 2 select timeout, 3 phase v, 4 byte, 5 byte with parity
  // error, 6 byte with bad identify, 7 command block done, 8 selected by ID v, 9 same with ATN
  task automatic act(input logic [3:0] k, input logic [2:0] v = 3'h0);
    bus_ev_t e;
    bus_ev_t q;
    e = '0;
    e.atn_in = atn_level;
    e.arb_won = (k == 4'h0);
    e.sel_done = (k == 4'h1);
    e.sel_timeout = (k == 4'h2);
    e.phase_valid = (k == 4'h3);
    e.phase = v;
    e.byte_done = (k == 4'h4) || (k == 4'h5) || (k == 4'h6);
    e.parity_err = (k == 4'h5);
    e.invalid_id = (k == 4'h6);
    e.cdb_done = (k == 4'h7);
    e.selected = (k == 4'h8) || (k == 4'h9);
    e.selected_with_attention_cause = (k == 4'h9);
    e.bus_id = v;
    repeat (slow) @(posedge ref_clk);
    ev <= e;
    @(posedge ref_clk);
    // Released lines: qualified fields flip so stale values never look valid
    q = '0;
    q.atn_in = atn_level;
    q.phase = ~v;
    q.bus_id = ~v;
    q.selected_with_attention_cause = ~e.selected_with_attention_cause;
    ev <= q;
    @(posedge ref_clk);
  endtask : act
endmodule : far_scsi_device

// *** dv/select_status_tb.sv ***
// Self-checking bench for the selection-sequence status reporter
`timescale 1ns/1ps
`include "select_status_cfg.svh"

module select_status_tb
  import select_status_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bus_ev_t ev;
  logic atn_out;
  fifo_wr_t fifo_wr;
  logic irq;
  logic [7:0] fifo_q[$]; // Bytes seen on the FIFO port
  int n_fail = 0;
  int total_checks = 0;
  localparam logic [3:0] k_arb = 4'h0, k_seldone = 4'h1, k_tmo = 4'h2, k_phase = 4'h3, k_byte = 4'h4;
  localparam logic [3:0] k_perr = 4'h5, k_badid = 4'h6, k_cdb = 4'h7, k_sel = 4'h8, k_selatn = 4'h9;

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  select_status u_select_status (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .atn_out(atn_out), .fifo_wr(fifo_wr), .irq(irq));
  far_scsi_device u_far_scsi_device (.ref_clk(ref_clk), .ev(ev));

  // Collect every pushed byte
  always @(posedge ref_clk) begin
    if (fifo_wr.push === 1'b1) begin
      fifo_q.push_back(fifo_wr.data);
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; no wait-state count assumed, the bound only cuts a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      check({31'h0, pready}, 32'h1);
      give_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask : rd

  task automatic far(input logic [3:0] k, input logic [2:0] v = 3'h0);
    u_far_scsi_device.act(k, v);
  endtask : far

  // Outputs are looked at on the falling edge, well away from updates
  task automatic peek_atn(input logic exp);
    @(negedge ref_clk);
    check({31'h0, atn_out}, {31'h0, exp});
    @(posedge ref_clk);
  endtask : peek_atn

  // Wait for the interrupt, then read and clear the stop report
  task automatic expect_stop(input logic [2:0] step, input logic [7:0] cause);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (irq !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    if (irq !== 1'b1) begin
      check({31'h0, irq}, 32'h1);
      give_verdict();
    end
    @(posedge ref_clk);
    apb(1'b0, `OFF_STATUS, 32'h0, q, e);
    check({31'h0, q[`STAT_IRQ_BIT]}, 32'h1);
    rd(`OFF_STEP, {29'h0, step});
    rd(`OFF_CAUSE, {24'h0, cause});
    rd(`OFF_STEP, 32'h0);
    rd(`OFF_CAUSE, 32'h0);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
  endtask : expect_stop

  task automatic init_sel(input logic [7:0] cmd);
    wr(`OFF_CMD, {24'h0, cmd});
    far(k_arb);
    far(k_seldone);
    far(k_phase, `PH_MSG_OUT);
  endtask : init_sel

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(`OFF_CONFIG, {24'h0, `CFG_RESET});
    // Upper write bits are junk on purpose; only the low byte may stick
    wr(`OFF_CONFIG, 32'ha5a5_5a03);
    rd(`OFF_CONFIG, 32'h0000_0003);
    wr(`OFF_CONFIG, {24'h0, `CFG_RESET});
    rd(`OFF_STEP, 32'h0);
    rd(`OFF_CAUSE, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_timeout_and_no_msgout;
    logic [7:0] cmds[3];
    cmds = '{`CMD_SELECTED_WITH_ATTENTION_CAUSE, `CMD_SEL_ATN3, `CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP};
    foreach (cmds[i]) begin
      wr(`OFF_CMD, {24'h0, cmds[i]});
      far(k_arb);
      far(k_tmo);
      expect_stop(3'h0, `CAUSE_DISC);
      wr(`OFF_CMD, {24'h0, cmds[i]});
      far(k_arb);
      far(k_seldone);
      far(k_phase, `PH_CMD);
      expect_stop(3'h0, `CAUSE_BS | `CAUSE_FC);
      peek_atn(1'b1);
    end
    $display("test timeout and no message out done");
  endtask : t_timeout_and_no_msgout

  task automatic t_selected_with_attention_cause;
    init_sel(`CMD_SELECTED_WITH_ATTENTION_CAUSE);
    far(k_byte);
    peek_atn(1'b0);
    u_far_scsi_device.slow = 2;
    far(k_phase, `PH_CMD);
    far(k_cdb);
    u_far_scsi_device.slow = 0;
    expect_stop(3'h4, `CAUSE_BS | `CAUSE_FC);
    init_sel(`CMD_SELECTED_WITH_ATTENTION_CAUSE);
    far(k_byte);
    far(k_phase, 3'h3);
    expect_stop(3'h2, `CAUSE_BS | `CAUSE_FC);
    init_sel(`CMD_SELECTED_WITH_ATTENTION_CAUSE);
    far(k_byte);
    far(k_phase, `PH_CMD);
    far(k_byte);
    far(k_phase, 3'h1);
    expect_stop(3'h3, `CAUSE_BS | `CAUSE_FC);
    $display("test select with attention done");
  endtask : t_selected_with_attention_cause

  task automatic t_sel_atn3_and_stop;
    init_sel(`CMD_SEL_ATN3);
    far(k_byte);
    peek_atn(1'b1);
    far(k_byte);
    peek_atn(1'b1);
    far(k_byte);
    peek_atn(1'b0);
    far(k_phase, `PH_CMD);
    far(k_cdb);
    expect_stop(3'h4, `CAUSE_BS | `CAUSE_FC);
    init_sel(`CMD_SEL_ATN3);
    far(k_byte);
    far(k_phase, 3'h0);
    expect_stop(3'h2, `CAUSE_BS | `CAUSE_FC);
    init_sel(`CMD_SELECTED_WITH_ATTENTION_CAUSE_STOP);
    far(k_byte);
    expect_stop(3'h1, `CAUSE_BS | `CAUSE_FC);
    peek_atn(1'b1);
    $display("test three bytes and stop done");
  endtask : t_sel_atn3_and_stop

  task automatic t_target_plain;
    wr(`OFF_CONFIG, 32'h0);
    fifo_q.delete();
    far(k_sel, 3'h5);
    expect_stop(3'h0, `CAUSE_SEL);
    check(fifo_q.size(), 32'h2);
    check({24'h0, fifo_q[0]}, 32'h20);
    check({24'h0, fifo_q[1]}, 32'h0);
    wr(`OFF_CONFIG, 32'h2);
    far(k_sel, 3'h2);
    u_far_scsi_device.set_atn(1'b1);
    far(k_perr);
    expect_stop(3'h1, `CAUSE_BS | `CAUSE_SEL);
    u_far_scsi_device.set_atn(1'b0);
    far(k_sel, 3'h2);
    far(k_byte);
    far(k_cdb);
    expect_stop(3'h2, `CAUSE_SEL);
    $display("test target without attention done");
  endtask : t_target_plain

  task automatic t_target_atn;
    wr(`OFF_CONFIG, 32'h0);
    far(k_selatn, 3'h1);
    far(k_badid);
    expect_stop(3'h0, `CAUSE_SELATN);
    far(k_selatn, 3'h1);
    far(k_perr);
    expect_stop(3'h0, `CAUSE_SELATN);
    u_far_scsi_device.set_atn(1'b1);
    far(k_selatn, 3'h1);
    far(k_byte);
    expect_stop(3'h0, `CAUSE_BS | `CAUSE_SELATN);
    u_far_scsi_device.set_atn(1'b0);
    far(k_selatn, 3'h1);
    far(k_byte);
    far(k_perr);
    expect_stop(3'h1, `CAUSE_SELATN);
    far(k_selatn, 3'h1);
    far(k_byte);
    u_far_scsi_device.set_atn(1'b1);
    far(k_cdb);
    expect_stop(3'h2, `CAUSE_BS | `CAUSE_SELATN);
    u_far_scsi_device.set_atn(1'b0);
    $display("test target with attention done");
  endtask : t_target_atn

  task automatic t_target_ext;
    wr(`OFF_CONFIG, 32'h1);
    far(k_selatn, 3'h3);
    far(k_byte);
    far(k_perr);
    expect_stop(3'h4, `CAUSE_SELATN);
    far(k_selatn, 3'h3);
    far(k_byte);
    far(k_byte);
    u_far_scsi_device.set_atn(1'b1);
    far(k_byte);
    expect_stop(3'h4, `CAUSE_BS | `CAUSE_SELATN);
    u_far_scsi_device.set_atn(1'b0);
    far(k_selatn, 3'h3);
    repeat (3) far(k_byte);
    u_far_scsi_device.set_atn(1'b1);
    far(k_perr);
    expect_stop(3'h5, `CAUSE_BS | `CAUSE_SELATN);
    u_far_scsi_device.set_atn(1'b0);
    far(k_selatn, 3'h3);
    repeat (3) far(k_byte);
    far(k_cdb);
    expect_stop(3'h6, `CAUSE_SELATN);
    $display("test extended target done");
  endtask : t_target_ext

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_timeout_and_no_msgout();
    t_selected_with_attention_cause();
    t_sel_atn3_and_stop();
    t_target_plain();
    t_target_atn();
    t_target_ext();
    give_verdict();
  end
endmodule : select_status_tb
